//--- bench/dacc_tb.sv
/*
 * self-checking bench of the two-channel converter control block: register
 * table, reserved bits, channel gating, restart, standby and reset.
 * assumes the block answers apb through its own pready and that settle
 * time is shortened to 5 clocks through the SETTLE_CYCLES parameter.
 */
`include "dacc_params.svh"
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ========================================================================
   // constants and signals
   localparam int unsigned SETTLE = 5; // shortened conversion time
   localparam logic [23:0] A_CH0 = {2'b00, `DACC_IDX_CH0, 2'b00};
   localparam logic [23:0] A_CH1 = {2'b00, `DACC_IDX_CH1, 2'b00};
   localparam logic [23:0] A_CTRL = {2'b00, `DACC_IDX_CTRL, 2'b00};
   localparam logic [23:0] A_STBY = {2'b00, `DACC_IDX_STBY, 2'b00};
   localparam logic [23:0] A_STAT = {2'b00, `DACC_IDX_STAT, 2'b00}; // read-only status
   localparam logic [23:0] A_NONE = {2'b00, 20'hFFF9F, 2'b00}; // unmapped word

   typedef struct packed {
      logic w;          // write when high
      logic [23:0] a;   // byte address
      logic [31:0] d;   // write data
      logic [31:0] x;   // expected read data
      logic e;          // expected error
   } dacc_row_t;

   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [23:0] i_paddr = 24'h000000;
   logic [31:0] i_pwdata = 32'h00000000;
   logic [3:0] i_pstrb = 4'hF;
   logic i_sw_standby = 1'b0;
   logic i_hw_standby = 1'b0;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, o_oe0, o_oe1;
   logic [7:0] o_code0, o_code1;
   int bad_count = 0;
   int checked = 0;
   logic [31:0] rd;
   logic er;
   logic [2:0] c;
   logic [7:0] d0, d1;

   // ordinary register cases
   dacc_row_t rows [12] = '{
      '{1'b1, A_CH0, 32'h000000A5, 32'h0, 1'b0},
      '{1'b0, A_CH0, 32'h0, 32'h000000A5, 1'b0},
      '{1'b1, A_CH1, 32'h0000005A, 32'h0, 1'b0},
      '{1'b0, A_CH1, 32'h0, 32'h0000005A, 1'b0},
      '{1'b1, A_CTRL, 32'h00000000, 32'h0, 1'b0},
      '{1'b0, A_CTRL, 32'h0, 32'h0000001F, 1'b0},
      '{1'b1, A_STBY, 32'h00000001, 32'h0, 1'b0},
      '{1'b0, A_STBY, 32'h0, 32'h000000FF, 1'b0},
      '{1'b1, A_CTRL, 32'hFFFFFFE0, 32'h0, 1'b0},
      '{1'b0, A_CTRL, 32'h0, 32'h000000FF, 1'b0},
      '{1'b0, A_NONE, 32'h0, 32'h0, 1'b1},
      '{1'b1, A_CH0 + 24'h000001, 32'h0, 32'h0, 1'b1}
   };

   // ========================================================================
   // clock and design
   always #4 i_mclk = ~i_mclk;

   dacc_top #(.ADDR_W(24), .SETTLE_CYCLES(SETTLE)) u_dut (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .i_sw_standby(i_sw_standby),
      .i_hw_standby(i_hw_standby), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .o_analog_out_ch0(o_code0),
      .o_analog_out_ch0_oe(o_oe0), .o_analog_out_ch1(o_code1),
      .o_analog_out_ch1_oe(o_oe1)
   );

   // ========================================================================
   // tasks
   // compare and count; prints its own line on a mismatch
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   // one apb transfer; ready and data are taken at the edge that ends it
   task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      i_pstrb <= s;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      @(posedge i_mclk);
      // ready is looked at on rising edges only, bounded
      while (o_pready !== 1'b1 && n < 20) begin
         @(posedge i_mclk);
         n++;
      end
      r = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n >= 20) chk(32'h1, 32'h0, "no ready");
   endtask

   // write with all strobes, then read back-check helpers
   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h000000, d}, 4'hF, rd, er);
   endtask

   task automatic rdchk(input logic [23:0] a, input logic [7:0] x);
      apb(1'b0, a, 32'h0, 4'hF, rd, er);
      chk(rd, {24'h000000, x}, "read data");
      chk({31'h0, er}, 32'h0, "read error");
   endtask

   // wait clocks, then look at the pins mid-cycle
   task automatic pins(input int n, input logic e0, input logic e1);
      repeat (n) @(posedge i_mclk);
      @(negedge i_mclk);
      chk({31'h0, o_oe0}, {31'h0, e0}, "pin 0 drive");
      chk({31'h0, o_oe1}, {31'h0, e1}, "pin 1 drive");
   endtask

   // standby entry with the keep bit given
   task automatic stby_run(input logic keep);
      wr(A_STBY, {7'h00, keep});
      wr(A_CTRL, 8'hC0);
      wr(A_CH0, 8'h22);
      repeat (SETTLE + 2) @(posedge i_mclk);
      i_sw_standby <= 1'b1;
      pins(3, keep, keep);
      if (keep) chk({24'h0, o_code0}, 32'h22, "held output");
      @(posedge i_mclk);
      i_sw_standby <= 1'b0;
      rdchk(A_CH0, keep ? 8'h22 : 8'h00);
      rdchk(A_CTRL, keep ? 8'hDF : 8'h1F);
      rdchk(A_STBY, keep ? 8'hFF : 8'hFE);
      $display("test software standby keep=%0d done", keep);
   endtask

   // verdict, reached from the main sequence or the watchdog
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ========================================================================
   // watchdog: whole run is well under 5000 clocks
   initial begin
      #300000;
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      summarize();
   end

   // ========================================================================
   // main sequence
   initial begin
      repeat (8) @(posedge i_mclk);
      i_resetn <= 1'b1;
      // table of ordinary register cases
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, 4'hF, rd, er);
         chk({31'h0, er}, {31'h0, rows[i].e}, "error flag");
         if (!rows[i].w && !rows[i].e) chk(rd, rows[i].x, "row read");
      end
      rdchk(A_CH0, 8'hA5);
      $display("test register table done");
      // every gating combination of bits 7, 6 and 5
      for (int k = 0; k < 8; k++) begin
         c = k[2:0];
         d0 = 8'h10 + 8'(k);
         d1 = 8'h80 + 8'(k);
         wr(A_CTRL, 8'h00);
         wr(A_CH0, d0);
         wr(A_CH1, d1);
         wr(A_CTRL, {c, 5'h00});
         pins(SETTLE + 2, c[1], c[2]);
         chk({31'h0, o_code0 === d0}, {31'h0, c[1] | (c[0] & c[2])}, "ch0 gate");
         chk({31'h0, o_code1 === d1}, {31'h0, c[2] | (c[0] & c[1])}, "ch1 gate");
      end
      $display("test gating done");
      // data rewrite mid-conversion restarts the count
      wr(A_CTRL, 8'h40);
      wr(A_CH0, 8'h33);
      repeat (SETTLE + 2) @(posedge i_mclk);
      wr(A_CH0, 8'h44);
      wr(A_CH0, 8'h55);
      pins(3, 1'b1, 1'b0);
      chk({24'h0, o_code0}, 32'h33, "old code kept");
      pins(3, 1'b1, 1'b0);
      chk({24'h0, o_code0}, 32'h55, "new code settled");
      // status: channel 0 settled and driven, channel 1 idle and undriven
      rdchk(A_STAT, 8'h24);
      $display("test restart done");
      stby_run(1'b0);
      stby_run(1'b1);
      // strobe-less write is ignored
      wr(A_CH1, 8'h77);
      apb(1'b1, A_CH1, 32'h00000033, 4'h0, rd, er);
      rdchk(A_CH1, 8'h77);
      // hardware standby clears the four registers and the pin drives; the settled codes are kept
      wr(A_CTRL, 8'hC0);
      @(posedge i_mclk);
      i_hw_standby <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_hw_standby <= 1'b0;
      pins(1, 1'b0, 1'b0);
      rdchk(A_STBY, 8'hFE);
      rdchk(A_CTRL, 8'h1F);
      rdchk(A_CH1, 8'h00);
      $display("test hardware standby done");
      // reset in mid-run
      wr(A_STBY, 8'h01);
      wr(A_CTRL, 8'hE0);
      wr(A_CH0, 8'h5C);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_resetn <= 1'b1;
      pins(1, 1'b0, 1'b0);
      rdchk(A_CH0, 8'h00);
      rdchk(A_CH1, 8'h00);
      rdchk(A_CTRL, 8'h1F);
      rdchk(A_STBY, 8'hFE);
      $display("test reset done");
      summarize();
   end
endmodule

`default_nettype wire

//--- core/dacc_chan.sv
/*
 * one channel converter: tracks the data code while enabled and reports the
 * settled code once the conversion time has passed.
 * assumes the register block drives conv_en and code from its flip-flops.
 */
`include "dacc_params.svh"
`default_nettype none

module dacc_chan #(
   parameter int unsigned SETTLE_CYCLES = `DACC_SETTLE_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   dacc_chan_if.chan ch
);

   // ========================================================================
   // parameter check: the pipeline eats two clocks of the budget
   localparam int unsigned LOADV = SETTLE_CYCLES - 1 - `DACC_PIPE_CYCLES;
   if (SETTLE_CYCLES < 3 || SETTLE_CYCLES > 65535) begin : g_bad_settle
      $error("dacc_chan: SETTLE_CYCLES must lie in 3..65535");
   end

   dacc_pkg::dacc_chan_st_t s_r;  // registered state
   dacc_pkg::dacc_chan_st_t s_nxt; // next state

   // ========================================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.conv_q = ch.conv_en;
      if (!ch.conv_en) begin
         // disabled: nothing converts
         s_nxt.st = dacc_pkg::DACC_IDLE;
         s_nxt.cnt = 16'h0000;
         s_nxt.done = 1'b0;
      end else if (!s_r.conv_q || ch.code != s_r.code) begin
         // new enable or changed data restarts at once
         s_nxt.st = dacc_pkg::DACC_CONV;
         s_nxt.code = ch.code;
         s_nxt.cnt = 16'(LOADV);
         s_nxt.done = 1'b0;
      end else begin
         case (s_r.st)
            dacc_pkg::DACC_IDLE: begin
               // hold the settled value
               s_nxt.st = dacc_pkg::DACC_IDLE;
            end
            dacc_pkg::DACC_CONV: begin
               if (s_r.cnt == 16'h0000) begin
                  // settled within the conversion time
                  s_nxt.st = dacc_pkg::DACC_IDLE;
                  s_nxt.result = s_r.code;
                  s_nxt.done = 1'b1;
               end else begin
                  s_nxt.cnt = s_r.cnt - 16'h0001;
               end
            end
            default: begin
               s_nxt.st = dacc_pkg::DACC_IDLE;
            end
         endcase
      end
   end

   // ========================================================================
   // state register
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ch.busy = (s_r.st == dacc_pkg::DACC_CONV);
   assign ch.done = s_r.done;
   assign ch.result = s_r.result;

   // ========================================================================
   // checks
   a_settle_bound: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      s_r.st == dacc_pkg::DACC_CONV |-> s_r.cnt <= 16'(LOADV))
      else $error("settle count above budget");

   a_change_restart: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (ch.conv_en && s_r.conv_q && ch.code != s_r.code)
      |=> (s_r.st == dacc_pkg::DACC_CONV && s_r.cnt == 16'(LOADV) && !s_r.done))
      else $error("data change did not restart conversion");

   a_result_held: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      $rose(s_r.done) |-> (s_r.result == s_r.code && $past(s_r.cnt) == 16'h0000))
      else $error("settled result differs from code");

endmodule

`default_nettype wire

//--- core/dacc_top.sv
/*
 * register block of the two-channel eight-bit converter: apb slave, channel
 * enables, joint conversion gating, standby handling and pin enables.
 * assumes synchronous standby inputs and an apb master on the same clock.
 */
`include "dacc_params.svh"
`default_nettype none

module dacc_top #(
   parameter int unsigned ADDR_W = 24,
   parameter int unsigned SETTLE_CYCLES = `DACC_SETTLE_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic i_sw_standby,
   input wire logic i_hw_standby,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [7:0] o_analog_out_ch0,
   output logic o_analog_out_ch0_oe,
   output logic [7:0] o_analog_out_ch1,
   output logic o_analog_out_ch1_oe
);

   // ========================================================================
   // parameter check
   if (ADDR_W < 22 || ADDR_W > 32) begin : g_bad_addr
      $error("dacc_top: ADDR_W must lie in 22..32");
   end

   localparam int unsigned IW = ADDR_W - 2; // word index width

   dacc_pkg::dacc_top_st_t s_r;   // registered state
   dacc_pkg::dacc_top_st_t s_nxt; // next state

   dacc_chan_if ch0_if (); // channel 0 link
   dacc_chan_if ch1_if (); // channel 1 link

   // ========================================================================
   // address decode, used in setup and access phase
   function automatic dacc_pkg::dacc_sel_t dec_addr(input logic [ADDR_W-1:0] a);
      logic [IW-1:0] idx;
      idx = a[ADDR_W-1:2];
      dec_addr = dacc_pkg::DACC_SEL_NONE;
      if (a[1:0] == 2'h0) begin
         if (idx == IW'(`DACC_IDX_CH0)) begin
            dec_addr = dacc_pkg::DACC_SEL_CH0;
         end else if (idx == IW'(`DACC_IDX_CH1)) begin
            dec_addr = dacc_pkg::DACC_SEL_CH1;
         end else if (idx == IW'(`DACC_IDX_CTRL)) begin
            dec_addr = dacc_pkg::DACC_SEL_CTRL;
         end else if (idx == IW'(`DACC_IDX_STBY)) begin
            dec_addr = dacc_pkg::DACC_SEL_STBY;
         end else if (idx == IW'(`DACC_IDX_STAT)) begin
            dec_addr = dacc_pkg::DACC_SEL_STAT;
         end
      end
   endfunction

   // ========================================================================
   // conversion gating per channel, joint bit included
   logic oe0_bit; // channel0_output_enable
   logic oe1_bit; // channel1_output_enable
   logic joint;   // joint_conversion_enable
   assign oe0_bit = s_r.ctrl_r[`DACC_CTRL_OE0];
   assign oe1_bit = s_r.ctrl_r[`DACC_CTRL_OE1];
   assign joint = s_r.ctrl_r[`DACC_CTRL_JOINT];

   // own enable, or the other one when joined
   assign ch0_if.conv_en = oe0_bit | (joint & oe1_bit);
   assign ch1_if.conv_en = oe1_bit | (joint & oe0_bit);
   assign ch0_if.code = s_r.ch0_r;
   assign ch1_if.code = s_r.ch1_r;

   // ========================================================================
   // channel converters
   dacc_chan #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_chan0 (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .ch(ch0_if.chan)
   );

   dacc_chan #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_chan1 (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .ch(ch1_if.chan)
   );

   // ========================================================================
   // status word: block state for software
   logic [31:0] status_w;
   assign status_w = {25'h0000000, s_r.oe1, s_r.oe0, s_r.swsb_q,
      ch1_if.done, ch0_if.done, ch1_if.busy, ch0_if.busy};

   // ========================================================================
   // apb phase terms
   dacc_pkg::dacc_sel_t sel;  // decoded register
   logic setup_ph;            // first cycle of a transfer
   logic access_ok;           // access phase completing now
   logic sw_entry;            // first clock of software standby
   logic out_allowed;         // pins may be driven now
   assign sel = dec_addr(i_paddr);
   assign setup_ph = i_psel & ~i_penable;
   assign access_ok = i_psel & i_penable & s_r.pready;
   assign sw_entry = i_sw_standby & ~s_r.swsb_q;
   // outputs survive software standby only with the standby bit
   assign out_allowed = ~i_hw_standby & (~i_sw_standby | s_r.stby_r[`DACC_STBY_EN]);

   // ========================================================================
   // next state: bus, standby, outputs
   always_comb begin
      s_nxt = s_r;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.swsb_q = i_sw_standby;

      // setup phase: answer in the next cycle with data or error
      if (setup_ph) begin
         s_nxt.pready = 1'b1;
         s_nxt.pslverr = (sel == dacc_pkg::DACC_SEL_NONE);
         case (sel)
            dacc_pkg::DACC_SEL_CH0: begin
               s_nxt.prdata = {24'h000000, s_r.ch0_r};
            end
            dacc_pkg::DACC_SEL_CH1: begin
               s_nxt.prdata = {24'h000000, s_r.ch1_r};
            end
            dacc_pkg::DACC_SEL_CTRL: begin
               s_nxt.prdata = {24'h000000, s_r.ctrl_r};
            end
            dacc_pkg::DACC_SEL_STBY: begin
               s_nxt.prdata = {24'h000000, s_r.stby_r};
            end
            dacc_pkg::DACC_SEL_STAT: begin
               s_nxt.prdata = status_w;
            end
            default: begin
               s_nxt.prdata = 32'h00000000;
            end
         endcase
      end

      // access phase write, low byte lane only
      if (access_ok && i_pwrite && !s_r.pslverr && i_pstrb[0]) begin
         case (sel)
            dacc_pkg::DACC_SEL_CH0: begin
               s_nxt.ch0_r = i_pwdata[7:0];
            end
            dacc_pkg::DACC_SEL_CH1: begin
               s_nxt.ch1_r = i_pwdata[7:0];
            end
            dacc_pkg::DACC_SEL_CTRL: begin
               // reserved bits stay one
               s_nxt.ctrl_r = i_pwdata[7:0] | `DACC_CTRL_RSVD;
            end
            dacc_pkg::DACC_SEL_STBY: begin
               s_nxt.stby_r = i_pwdata[7:0] | `DACC_STBY_RSVD;
            end
            default: begin
               s_nxt.prdata = s_r.prdata;
            end
         endcase
      end

      // software standby entry clears unless the standby bit is set
      if (sw_entry && !s_r.stby_r[`DACC_STBY_EN]) begin
         s_nxt.ch0_r = `DACC_RST_DATA;
         s_nxt.ch1_r = `DACC_RST_DATA;
         s_nxt.ctrl_r = `DACC_RST_CTRL;
      end

      // hardware standby clears every register
      if (i_hw_standby) begin
         s_nxt.ch0_r = `DACC_RST_DATA;
         s_nxt.ch1_r = `DACC_RST_DATA;
         s_nxt.ctrl_r = `DACC_RST_CTRL;
         s_nxt.stby_r = `DACC_RST_STBY;
      end

      // pin drive follows each enable alone
      s_nxt.oe0 = oe0_bit & out_allowed;
      s_nxt.oe1 = oe1_bit & out_allowed;
      // settled code, scaled by the analog stage as code/256 of reference
      s_nxt.code0 = ch0_if.result;
      s_nxt.code1 = ch1_if.result;
   end

   // ========================================================================
   // state register
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_r <= '0;
         s_r.ctrl_r <= `DACC_RST_CTRL;
         s_r.stby_r <= `DACC_RST_STBY;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ========================================================================
   // outputs straight from flip-flops
   assign o_prdata = s_r.prdata;
   assign o_pready = s_r.pready;
   assign o_pslverr = s_r.pslverr;
   assign o_analog_out_ch0 = s_r.code0;
   assign o_analog_out_ch0_oe = s_r.oe0;
   assign o_analog_out_ch1 = s_r.code1;
   assign o_analog_out_ch1_oe = s_r.oe1;

   // ========================================================================
   // checks
   a_ctrl_reserved: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      s_r.ctrl_r[4:0] == 5'h1F && s_r.stby_r[7:1] == 7'h7F)
      else $error("reserved bits not one");

   sequence sq_sw_entry_clr;
      $rose(i_sw_standby) && !s_r.stby_r[0] && !i_hw_standby;
   endsequence

   sequence sq_sw_entry_keep;
      $rose(i_sw_standby) && s_r.stby_r[0] && !i_hw_standby && !i_psel;
   endsequence

   a_sw_clear: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      sq_sw_entry_clr |=> (s_r.ch0_r == 8'h00 && s_r.ch1_r == 8'h00 && s_r.ctrl_r == 8'h1F))
      else $error("software standby did not clear");

   a_sw_keep: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      sq_sw_entry_keep |=> ($stable(s_r.ch0_r) && $stable(s_r.ch1_r) && $stable(s_r.ctrl_r)))
      else $error("software standby lost register contents");

   a_hw_clear: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      i_hw_standby |=> (s_r.stby_r == 8'hFE && s_r.ctrl_r == 8'h1F && !o_analog_out_ch0_oe))
      else $error("hardware standby did not clear");

   a_joint_gate: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (joint && (oe0_bit || oe1_bit)) |-> (ch0_if.conv_en && ch1_if.conv_en))
      else $error("joint bit did not run both channels");

   a_both_off: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (!oe0_bit && !oe1_bit) |=> (!ch0_if.busy && !ch1_if.busy))
      else $error("conversion with both enables clear");

   a_sw_out_off: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (i_sw_standby && !s_r.stby_r[0]) |=> !o_analog_out_ch0_oe && !o_analog_out_ch1_oe)
      else $error("pin driven in software standby");

   a_pin_follow: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (!i_sw_standby && !i_hw_standby) |=> (o_analog_out_ch1_oe == $past(oe1_bit)))
      else $error("pin drive does not follow enable");

   a_apb_ready: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      setup_ph |=> (o_pready && o_pslverr == (sel == dacc_pkg::DACC_SEL_NONE)))
      else $error("apb answer missing");

endmodule

`default_nettype wire

//--- pkg/dacc_chan_if.sv
/*
 * link between the register block and one channel converter.
 * assumes both ends run on the same clock.
 */
`default_nettype none

interface dacc_chan_if;
   logic conv_en;       // conversion enabled
   logic [7:0] code;    // data register value
   logic busy;          // settling
   logic done;          // result valid for current code
   logic [7:0] result;  // settled code

   // register block side
   modport ctl (output conv_en, output code, input busy, input done, input result);
   // converter side
   modport chan (input conv_en, input code, output busy, output done, output result);
endinterface

`default_nettype wire

//--- pkg/dacc_params.svh
/*
 * constants of the two-channel converter control block: register indexes,
 * field positions, reset values and conversion timing.
 * assumes a 125 MHz system clock and 32-bit apb with word-aligned registers.
 */
`ifndef DACC_PARAMS_SVH
`define DACC_PARAMS_SVH

// ==========================================================================
// register indexes (byte address is four times the index)
`define DACC_IDX_CH0 20'hFFF9C
`define DACC_IDX_CH1 20'hFFF9D
`define DACC_IDX_CTRL 20'hFFF9E
`define DACC_IDX_STBY 20'hEE01A
`define DACC_IDX_STAT 20'hEE01B

// ==========================================================================
// reset values and reserved masks
`define DACC_RST_DATA 8'h00
`define DACC_RST_CTRL 8'h1F
`define DACC_RST_STBY 8'hFE
`define DACC_CTRL_RSVD 8'h1F
`define DACC_STBY_RSVD 8'hFE

// ==========================================================================
// field positions
`define DACC_CTRL_OE1 7
`define DACC_CTRL_OE0 6
`define DACC_CTRL_JOINT 5
`define DACC_STBY_EN 0

// ==========================================================================
// timing: longest conversion time, rounded down to whole clocks
`define DACC_CONV_TIME_NS 10000
`define DACC_CLK_PERIOD_NS 8
`define DACC_SETTLE_CYCLES (`DACC_CONV_TIME_NS / `DACC_CLK_PERIOD_NS)
`define DACC_PIPE_CYCLES 2

`endif

//--- pkg/dacc_pkg.sv
/*
 * types of the two-channel converter control block.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none

package dacc_pkg;

   // ========================================================================
   // channel converter state
   typedef enum logic [0:0] {DACC_IDLE, DACC_CONV} dacc_cstate_t;

   // register selected by an apb address
   typedef enum logic [2:0] {DACC_SEL_NONE, DACC_SEL_CH0, DACC_SEL_CH1, DACC_SEL_CTRL,
      DACC_SEL_STBY, DACC_SEL_STAT} dacc_sel_t;

   // all state of one channel converter
   typedef struct packed {
      dacc_cstate_t st;    // idle or settling
      logic [15:0] cnt;    // settle cycles left
      logic [7:0] code;    // code being converted
      logic [7:0] result;  // last settled code
      logic done;          // result matches enabled code
      logic conv_q;        // conversion enable, one clock late
   } dacc_chan_st_t;

   // all state of the register block
   typedef struct packed {
      logic [7:0] ch0_r;   // channel0_value
      logic [7:0] ch1_r;   // channel1_value
      logic [7:0] ctrl_r;  // converter_control
      logic [7:0] stby_r;  // standby_output_control
      logic swsb_q;        // software standby, one clock late
      logic [31:0] prdata; // apb read data
      logic pready;        // apb ready
      logic pslverr;       // apb error
      logic [7:0] code0;   // channel 0 output code
      logic [7:0] code1;   // channel 1 output code
      logic oe0;           // channel 0 pin driven
      logic oe1;           // channel 1 pin driven
   } dacc_top_st_t;

endpackage

`default_nettype wire
